// ===== verilog/fsf_pkg.sv
// Constants, register map and types for the flash status flag block
package fsf_pkg;
	// Register byte offsets on the APB port
	localparam logic [7:0] FSF_OFF_STATUS   = 8'h00;
	localparam logic [7:0] FSF_OFF_ECC      = 8'h04;
	localparam logic [7:0] FSF_OFF_CTRL     = 8'h08;
	localparam logic [7:0] FSF_OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] FSF_OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] FSF_OFF_CRC      = 8'h14;
	// device_status_flags field positions
	localparam int FSF_ST_ERR   = 4;
	localparam int FSF_ST_ABORT = 3;
	localparam int FSF_ST_SUSP  = 2;
	localparam int FSF_ST_PROT  = 1;
	localparam int FSF_ST_ERASE = 0;
	// ecc_unit_status field positions
	localparam int FSF_EC_DOUBLE   = 3;
	localparam int FSF_EC_SINGLE   = 1;
	localparam int FSF_EC_DISABLED = 0;
	// Control register fields
	localparam int FSF_CTRL_CLEAR    = 0;
	localparam int FSF_CTRL_EVAL     = 1;
	localparam int FSF_CTRL_SECT_LSB = 8;
	// Interrupt bit positions
	localparam int FSF_IRQ_ERR    = 0;
	localparam int FSF_IRQ_ABORT  = 1;
	localparam int FSF_IRQ_PROT   = 2;
	localparam int FSF_IRQ_DOUBLE = 3;
	localparam int FSF_IRQ_SINGLE = 4;
	localparam int FSF_IRQ_W      = 5;
	// Sizes
	localparam int FSF_SECT_W = 4;
	localparam int FSF_NSECT  = 16;
	localparam int FSF_ADDR_W = 32;
	// Reset values
	localparam logic [7:0]         FSF_RST_STATUS = 8'h00;
	localparam logic [15:0]        FSF_RST_ECC    = 16'h0000;
	localparam logic [FSF_IRQ_W-1:0] FSF_RST_IRQ  = 5'h00;
	localparam logic [FSF_NSECT-1:0] FSF_RST_SECT = 16'h0000;
	// APB slave states
	typedef enum logic [1:0] {
		FSF_APB_IDLE = 2'b01,
		FSF_APB_RESP = 2'b10
	} fsf_apb_e;
endpackage : fsf_pkg

// ===== verilog/fsf_erase_if.sv
// Link between the flag logic and the sector erase result table
`timescale 1ns/1ps
`default_nettype none
interface fsf_erase_if;
	import fsf_pkg::*;
	logic                  erase_done;
	logic                  erase_ok;
	logic [FSF_SECT_W-1:0] erase_sector;
	logic                  eval_req;
	logic [FSF_SECT_W-1:0] eval_sector;
	logic                  eval_done;
	logic                  eval_result;
	modport flags (output erase_done, erase_ok, erase_sector, eval_req, eval_sector,
		input eval_done, eval_result);
	modport lookup (input erase_done, erase_ok, erase_sector, eval_req, eval_sector,
		output eval_done, eval_result);
endinterface : fsf_erase_if
`default_nettype wire

// ===== verilog/fsf_erase_table.sv
// Per-sector erase result table answering evaluate-erase-status requests
`timescale 1ns/1ps
`default_nettype none
module fsf_erase_table
	import fsf_pkg::*;
(
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  nrst,
	// Flag logic side
	fsf_erase_if.lookup link
);
	logic [FSF_NSECT-1:0] sect_ok;
	logic [FSF_NSECT-1:0] next_sect_ok;
	logic                 next_eval_done;
	logic                 next_eval_result;

	////////////////////////////////////////////////////////////////////////////////
	// One result bit per sector, rewritten by each erase of that sector
	genvar g;
	generate
		for (g = 0; g < FSF_NSECT; g++) begin : g_sect
			always_comb begin
				next_sect_ok[g] = sect_ok[g];
				if (link.erase_done && (link.erase_sector == FSF_SECT_W'(g)))
					next_sect_ok[g] = link.erase_ok;
			end
		end
	endgenerate

	// Lookup takes one cycle; an erase finishing in the same cycle is seen next time
	always_comb begin
		next_eval_done   = link.eval_req;
		next_eval_result = link.eval_result;
		if (link.eval_req)
			next_eval_result = sect_ok[link.eval_sector];
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sect_ok          <= FSF_RST_SECT;
			link.eval_done   <= 1'b0;
			link.eval_result <= 1'b0;
		end else begin
			sect_ok          <= next_sect_ok;
			link.eval_done   <= next_eval_done;
			link.eval_result <= next_eval_result;
		end
	end

	property p_eval_answer;
		@(posedge ref_clk) disable iff (!nrst)
		link.eval_req |=> link.eval_done && (link.eval_result == $past(sect_ok[link.eval_sector]));
	endproperty
	a_eval_answer: assert property (p_eval_answer) else $error("erase lookup wrong");
endmodule : fsf_erase_table
`default_nettype wire

// ===== verilog/fsf_status_top.sv
// Status and ECC status flag bank of a serial flash, with APB register access
//
// Operation
// - A write-buffer abort sets both the program error flag and the buffer abort flag at once.
// - The abort status clears on the next successful program or on a clear-status command.
// - A CRC end address below start plus one aborts the calculation and sets buffer abort.
// - After such an abort the CRC result is marked not valid.
// - Status bit 3 reads one after a buffer program or CRC end-address load aborted.
// - Status bit 2 reads one while a program is suspended.
// - Status bit 1 reflects a protection failure of the latest program or erase.
// - After an evaluate-erase-status command status bit 0 shows that sector's erase result.
// - ECC status bit 3 reads one when a 2-bit error was found in the unit.
// - ECC status bit 1 reads one when a 1-bit error was corrected in the unit.
// - ECC status bit 0 reads one when correction is off for the unit.
// - Reserved ECC status bits read zero and are written as zero.
// - The program error flag stays set until clear-status or reset.
// - Standby is not allowed while the program error flag is set.
`timescale 1ns/1ps
`default_nettype none
module fsf_status_top
	import fsf_pkg::*;
(
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	// APB slave
	input  wire logic [7:0]            paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Program and erase engine events
	input  wire logic                  prog_done,
	input  wire logic                  prog_ok,
	input  wire logic                  prog_prot_fail,
	input  wire logic                  buf_abort_evt,
	input  wire logic                  prog_suspended,
	input  wire logic                  erase_done,
	input  wire logic                  erase_ok,
	input  wire logic                  erase_prot_fail,
	input  wire logic [FSF_SECT_W-1:0] erase_sector,
	// CRC address load
	input  wire logic                  crc_load,
	input  wire logic [FSF_ADDR_W-1:0] crc_start_address,
	input  wire logic [FSF_ADDR_W-1:0] crc_end_address,
	// ECC result of a unit read
	input  wire logic                  ecc_valid,
	input  wire logic                  ecc_double,
	input  wire logic                  ecc_single,
	input  wire logic                  ecc_disabled,
	// Power management, CRC status and interrupt
	input  wire logic                  standby_req,
	output logic                       standby_ok,
	output logic                       crc_abort,
	output logic                       crc_result_valid,
	output logic                       irq
);
	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	fsf_erase_if link ();

	fsf_apb_e             state;
	fsf_apb_e             next_state;
	logic [31:0]          next_prdata;
	logic                 next_pready;
	logic                 next_pslverr;
	logic                 program_error_flag;
	logic                 buffer_abort_flag;
	logic                 program_suspended_flag;
	logic                 protection_error_flag;
	logic                 sector_erase_ok_flag;
	logic                 next_program_error_flag;
	logic                 next_buffer_abort_flag;
	logic                 next_protection_error_flag;
	logic                 next_sector_erase_ok_flag;
	logic [15:0]          ecc_unit_status;
	logic [15:0]          next_ecc_unit_status;
	logic                 next_crc_abort;
	logic                 next_crc_result_valid;
	logic                 next_standby_ok;
	logic [FSF_IRQ_W-1:0] irq_stat;
	logic [FSF_IRQ_W-1:0] irq_mask;
	logic [FSF_IRQ_W-1:0] next_irq_stat;
	logic [FSF_IRQ_W-1:0] next_irq_mask;
	logic [FSF_IRQ_W-1:0] irq_evt;
	logic                 next_irq;
	logic [7:0]           device_status_flags;
	logic                 wr_en;
	logic                 clear_cmd;
	logic                 crc_bad;
	logic                 prog_fail;

	// Register hit test, shared by read mux and write strobes
	function automatic logic fsf_hit(input logic [7:0] addr, input logic [7:0] off);
		fsf_hit = (addr == off);
	endfunction : fsf_hit

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait cycle, so pready and prdata can come from flops
	assign wr_en = psel && penable && pready && pwrite;

	always_comb begin
		next_state   = state;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		next_prdata  = prdata;
		case (state)
			FSF_APB_IDLE: begin
				if (psel && penable) begin
					next_state   = FSF_APB_RESP;
					next_pready  = 1'b1;
					next_pslverr = 1'b1;
					next_prdata  = 32'h0000_0000;
					if (fsf_hit(paddr, FSF_OFF_STATUS)) begin
						next_pslverr = pwrite;
						next_prdata  = {24'h00_0000, device_status_flags};
					end else if (fsf_hit(paddr, FSF_OFF_ECC)) begin
						next_pslverr = pwrite;
						next_prdata  = {16'h0000, ecc_unit_status};
					end else if (fsf_hit(paddr, FSF_OFF_CTRL)) begin
						next_pslverr = 1'b0;
					end else if (fsf_hit(paddr, FSF_OFF_IRQ_STAT)) begin
						next_pslverr = 1'b0;
						next_prdata  = {27'h000_0000, irq_stat};
					end else if (fsf_hit(paddr, FSF_OFF_IRQ_MASK)) begin
						next_pslverr = 1'b0;
						next_prdata  = {27'h000_0000, irq_mask};
					end else if (fsf_hit(paddr, FSF_OFF_CRC)) begin
						next_pslverr = pwrite;
						next_prdata  = {31'h0000_0000, crc_result_valid};
					end
					if (!pwrite && next_pslverr)
						next_prdata = 32'h0000_0000;
				end
			end
			FSF_APB_RESP: next_state = FSF_APB_IDLE;
			default:      next_state = FSF_APB_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state   <= FSF_APB_IDLE;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			state   <= next_state;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode and engine conditions
	assign clear_cmd   = wr_en && fsf_hit(paddr, FSF_OFF_CTRL) && pwdata[FSF_CTRL_CLEAR];
	assign prog_fail   = prog_done && !prog_ok;
	// Widened by one bit so start plus one cannot wrap at the top address
	assign crc_bad     = crc_load && ({1'b0, crc_end_address} <
		({1'b0, crc_start_address} + 33'h0_0000_0001));

	assign link.erase_done   = erase_done;
	assign link.erase_ok     = erase_ok;
	assign link.erase_sector = erase_sector;
	assign link.eval_req     = wr_en && fsf_hit(paddr, FSF_OFF_CTRL) && pwdata[FSF_CTRL_EVAL];
	assign link.eval_sector  = pwdata[FSF_CTRL_SECT_LSB +: FSF_SECT_W];

	fsf_erase_table u_erase_table (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.link    (link)
	);

	assign device_status_flags = {3'h0, program_error_flag, buffer_abort_flag,
		program_suspended_flag, protection_error_flag, sector_erase_ok_flag};

	////////////////////////////////////////////////////////////////////////////////
	// Status flags: every set is applied after the clear, so a same-cycle event wins
	always_comb begin
		next_program_error_flag = program_error_flag;
		if (clear_cmd)
			next_program_error_flag = 1'b0;
		if (buf_abort_evt || prog_fail)
			next_program_error_flag = 1'b1;

		next_buffer_abort_flag = buffer_abort_flag;
		if (clear_cmd || (prog_done && prog_ok))
			next_buffer_abort_flag = 1'b0;
		if (buf_abort_evt || crc_bad)
			next_buffer_abort_flag = 1'b1;

		next_protection_error_flag = protection_error_flag;
		if (prog_done || erase_done)
			next_protection_error_flag = (prog_done && prog_prot_fail) ||
				(erase_done && erase_prot_fail);

		next_sector_erase_ok_flag = sector_erase_ok_flag;
		if (link.eval_done)
			next_sector_erase_ok_flag = link.eval_result;

		next_ecc_unit_status = ecc_unit_status;
		if (ecc_valid) begin
			next_ecc_unit_status                  = FSF_RST_ECC;
			next_ecc_unit_status[FSF_EC_DOUBLE]   = ecc_double;
			next_ecc_unit_status[FSF_EC_SINGLE]   = ecc_single;
			next_ecc_unit_status[FSF_EC_DISABLED] = ecc_disabled;
		end

		next_crc_abort        = crc_bad;
		next_crc_result_valid = crc_result_valid;
		if (crc_load)
			next_crc_result_valid = !crc_bad;

		// Uses the flag as it will be, so standby drops the cycle an error lands
		next_standby_ok = standby_req && !next_program_error_flag;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			program_error_flag     <= FSF_RST_STATUS[FSF_ST_ERR];
			buffer_abort_flag      <= FSF_RST_STATUS[FSF_ST_ABORT];
			program_suspended_flag <= FSF_RST_STATUS[FSF_ST_SUSP];
			protection_error_flag  <= FSF_RST_STATUS[FSF_ST_PROT];
			sector_erase_ok_flag   <= FSF_RST_STATUS[FSF_ST_ERASE];
			ecc_unit_status        <= FSF_RST_ECC;
			crc_abort              <= 1'b0;
			crc_result_valid       <= 1'b0;
			standby_ok             <= 1'b0;
		end else begin
			program_error_flag     <= next_program_error_flag;
			buffer_abort_flag      <= next_buffer_abort_flag;
			program_suspended_flag <= prog_suspended;
			protection_error_flag  <= next_protection_error_flag;
			sector_erase_ok_flag   <= next_sector_erase_ok_flag;
			ecc_unit_status        <= next_ecc_unit_status;
			crc_abort              <= next_crc_abort;
			crc_result_valid       <= next_crc_result_valid;
			standby_ok             <= next_standby_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky events, write one to clear, set wins over clear
	assign irq_evt = {ecc_valid && ecc_single, ecc_valid && ecc_double,
		next_protection_error_flag && !protection_error_flag,
		buf_abort_evt || crc_bad, buf_abort_evt || prog_fail};

	always_comb begin
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		if (wr_en && fsf_hit(paddr, FSF_OFF_IRQ_STAT))
			next_irq_stat = irq_stat & ~pwdata[FSF_IRQ_W-1:0];
		if (wr_en && fsf_hit(paddr, FSF_OFF_IRQ_MASK))
			next_irq_mask = pwdata[FSF_IRQ_W-1:0];
		next_irq_stat = next_irq_stat | irq_evt;
		next_irq      = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat <= FSF_RST_IRQ;
			irq_mask <= FSF_RST_IRQ;
			irq      <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			irq      <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_setup;
		psel && !penable && (state == FSF_APB_IDLE);
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	property p_apb_answer;
		s_setup ##1 s_access |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

	property p_abort_sets;
		buf_abort_evt |=> program_error_flag && buffer_abort_flag;
	endproperty
	a_abort_sets: assert property (p_abort_sets) else $error("abort flags not set");
	property p_ok_clears;
		prog_done && prog_ok && !buf_abort_evt && !crc_bad |=> !buffer_abort_flag;
	endproperty
	a_ok_clears: assert property (p_ok_clears) else $error("abort not cleared");
	property p_crc_abort;
		crc_bad |=> crc_abort && buffer_abort_flag ##1 (!crc_abort || $past(crc_bad));
	endproperty
	a_crc_abort: assert property (p_crc_abort) else $error("crc abort missing");
	property p_crc_invalid;
		crc_bad |=> !crc_result_valid;
	endproperty
	a_crc_invalid: assert property (p_crc_invalid) else $error("crc result kept valid");
	property p_suspend;
		##1 program_suspended_flag == $past(prog_suspended);
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend flag lags");
	property p_prot;
		prog_done && !erase_done |=> protection_error_flag == $past(prog_prot_fail);
	endproperty
	a_prot: assert property (p_prot) else $error("protection flag wrong");
	property p_ecc_load;
		ecc_valid |=> ecc_unit_status ==
			{12'h000, $past(ecc_double), 1'b0, $past(ecc_single), $past(ecc_disabled)};
	endproperty
	a_ecc_load: assert property (p_ecc_load) else $error("ecc status wrong");
	property p_reserved;
		(ecc_unit_status[15:4] == 12'h000) && !ecc_unit_status[2];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved ecc bit set");

	property p_err_sticky;
		program_error_flag && !clear_cmd |=> program_error_flag;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

	property p_standby;
		program_error_flag |-> !standby_ok;
	endproperty
	a_standby: assert property (p_standby) else $error("standby with error set");
endmodule : fsf_status_top
`default_nettype wire

// ===== tb/fsf_host_model.sv
// APB host controller model that reaches the flag registers
`timescale 1ns/1ps
`default_nettype none
module fsf_host_model
	import fsf_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// APB master
	input  wire logic        pready,
	output var  logic [7:0]  paddr,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [31:0] pwdata,
	// Transfer outstanding
	output var  logic        hang
);
	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		hang = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One transfer; held until pready is sampled high at a rising edge
	task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
		while (nrst !== 1'b1) @(posedge ref_clk);
		@(posedge ref_clk);
		hang    <= 1'b1;
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= wr;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// No cycle limit here: only the bench watchdog ends a stalled wait
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		hang    <= 1'b0;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : fsf_host_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the flash status flag bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fsf_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic e;} fsf_note_s;
	logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, hang;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, ca;
	logic        prog_done, prog_ok, prog_prot_fail, buf_abort_evt, prog_suspended;
	logic        erase_done, erase_ok, erase_prot_fail, crc_load;
	logic        ecc_valid, ecc_double, ecc_single, ecc_disabled;
	logic        standby_req, standby_ok, crc_abort, crc_result_valid, irq;
	logic [3:0]  erase_sector, s, t;
	logic [31:0] crc_start_address, crc_end_address;
	logic [2:0]  eb;
	fsf_note_s   notes[$];
	int          error_cnt, checked;

	fsf_host_model host (.ref_clk(ref_clk), .nrst(nrst), .pready(pready), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .hang(hang));
	fsf_status_top dut (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .prog_done(prog_done), .prog_ok(prog_ok),
		.prog_prot_fail(prog_prot_fail), .buf_abort_evt(buf_abort_evt),
		.prog_suspended(prog_suspended), .erase_done(erase_done), .erase_ok(erase_ok),
		.erase_prot_fail(erase_prot_fail), .erase_sector(erase_sector), .crc_load(crc_load),
		.crc_start_address(crc_start_address), .crc_end_address(crc_end_address),
		.ecc_valid(ecc_valid), .ecc_double(ecc_double), .ecc_single(ecc_single),
		.ecc_disabled(ecc_disabled), .standby_req(standby_req), .standby_ok(standby_ok),
		.crc_abort(crc_abort), .crc_result_valid(crc_result_valid), .irq(irq));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register access notes its expectation before the host runs the cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic e);
		notes.push_back('{a, d, m, e});
		host.xfer(a, 1'b0, 32'h0);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		notes.push_back('{a, 32'h0, 32'h0, e});
		host.xfer(a, 1'b1, d);
	endtask : wr
	task automatic check_bit(input string nm, input logic e, input logic v);
		checked++;
		if (v !== e) begin
			error_cnt++;
			$display("ERROR %s exp %b seen %b", nm, e, v);
		end
	endtask : check_bit
	task automatic check_reg(input fsf_note_s n);
		checked++;
		if ((prdata & n.m) !== (n.d & n.m) || pslverr !== n.e) begin
			error_cnt++;
			$display("ERROR reg %h exp %h/%b seen %h/%b", n.a, n.d, n.e, prdata, pslverr);
		end
	endtask : check_reg
	task automatic conclude;
		if (notes.size() != 0 || hang === 1'b1)
			error_cnt++;
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// Monitor: the oldest note meets each answer while pready stands
	always @(negedge ref_clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
			check_reg(notes.pop_front());
	end

	// Watchdog, far beyond the length of the sequence
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{nrst, prog_done, prog_ok, prog_prot_fail, buf_abort_evt, prog_suspended} = 6'h00;
		{erase_done, erase_ok, erase_prot_fail, crc_load, ecc_valid} = 5'h00;
		{ecc_double, ecc_single, ecc_disabled, standby_req} = 4'h1;
		erase_sector = 4'h0;
		crc_start_address = 32'h0;
		crc_end_address = 32'h0;
		error_cnt = 0;
		checked = 0;
		void'($urandom(32'h2081));
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		// Reset values, map and refusals
		rd(FSF_OFF_STATUS, 32'h0, 32'hFF, 1'b0);
		rd(FSF_OFF_ECC, 32'h0, 32'hFFFF, 1'b0);
		rd(FSF_OFF_IRQ_STAT, 32'h0, 32'h1F, 1'b0);
		rd(FSF_OFF_CRC, 32'h0, 32'h1, 1'b0);
		rd(8'h18, 32'h0, 32'hFFFFFFFF, 1'b1);
		wr(FSF_OFF_ECC, 32'h0, 1'b1);
		wr(FSF_OFF_IRQ_MASK, 32'h1F, 1'b0);
		rd(FSF_OFF_IRQ_MASK, 32'h1F, 32'h1F, 1'b0);
		$display("test map done");
		// Abort, then clear-status directly or a good program first
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			buf_abort_evt <= 1'b1;
			@(posedge ref_clk);
			buf_abort_evt <= 1'b0;
			@(negedge ref_clk);
			check_bit("irq", 1'b1, irq);
			@(negedge ref_clk);
			check_bit("standby_ok", 1'b0, standby_ok);
			rd(FSF_OFF_STATUS, 32'h18, 32'h1F, 1'b0);
			rd(FSF_OFF_IRQ_STAT, 32'h3, 32'h1F, 1'b0);
			if (k == 1) begin
				@(posedge ref_clk);
				{prog_done, prog_ok} <= 2'h3;
				@(posedge ref_clk);
				{prog_done, prog_ok} <= 2'h0;
				rd(FSF_OFF_STATUS, 32'h10, 32'h1F, 1'b0);
			end
			wr(FSF_OFF_CTRL, 32'h1, 1'b0);
			rd(FSF_OFF_STATUS, 32'h0, 32'h1F, 1'b0);
			check_bit("standby_ok", 1'b1, standby_ok);
			wr(FSF_OFF_IRQ_STAT, 32'h1F, 1'b0);
			repeat (2) @(negedge ref_clk);
			check_bit("irq", 1'b0, irq);
		end
		$display("test abort done");
		// Standby follows the request when no program error is pending
		@(posedge ref_clk);
		standby_req <= 1'b0;
		repeat (2) @(negedge ref_clk);
		check_bit("standby_ok", 1'b0, standby_ok);
		@(posedge ref_clk);
		standby_req <= 1'b1;
		// Suspend follows the level
		for (int k = 1; k >= 0; k--) begin
			@(posedge ref_clk);
			prog_suspended <= k[0];
			rd(FSF_OFF_STATUS, {29'h0, k[0], 2'h0}, 32'h4, 1'b0);
		end
		$display("test suspend done");
		// Protection error follows the latest program or erase
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			{prog_done, prog_prot_fail} <= {~k[0], k[1]};
			{erase_done, erase_prot_fail} <= {k[0], k[1]};
			@(posedge ref_clk);
			{prog_done, prog_prot_fail, erase_done, erase_prot_fail} <= 4'h0;
			rd(FSF_OFF_STATUS, {30'h0, k[1], 1'h0}, 32'h2, 1'b0);
		end
		wr(FSF_OFF_CTRL, 32'h1, 1'b0);
		$display("test protection done");
		// Erase result per sector, read after an evaluate request
		s = 4'($urandom);
		t = s ^ 4'($urandom_range(15, 1));
		for (int k = 0; k < 3; k++) begin
			@(posedge ref_clk);
			{erase_done, erase_ok} <= {1'b1, k != 2};
			erase_sector <= s;
			@(posedge ref_clk);
			{erase_done, erase_ok} <= 2'h0;
			wr(FSF_OFF_CTRL, {20'h0, (k == 1) ? t : s, 8'h2}, 1'b0);
			repeat (2) @(posedge ref_clk);
			rd(FSF_OFF_STATUS, {31'h0, k == 0}, 32'h1, 1'b0);
		end
		$display("test erase done");
		// CRC end address at the boundary, aborting then accepted
		ca = $urandom & 32'h7FFFFFFF;
		for (int k = 0; k < 2; k++) begin
			wr(FSF_OFF_CTRL, 32'h1, 1'b0);
			@(posedge ref_clk);
			crc_load <= 1'b1;
			crc_start_address <= ca;
			crc_end_address <= ca + k;
			@(posedge ref_clk);
			crc_load <= 1'b0;
			@(negedge ref_clk);
			check_bit("crc_abort", k == 0, crc_abort);
			check_bit("crc_result_valid", k == 1, crc_result_valid);
			rd(FSF_OFF_CRC, {31'h0, k == 1}, 32'h1, 1'b0);
			rd(FSF_OFF_STATUS, {28'h0, k == 0, 3'h0}, 32'h8, 1'b0);
		end
		$display("test crc done");
		// Every ECC result combination, then random ones
		for (int k = 0; k < 12; k++) begin
			eb = (k < 8) ? 3'(k) : 3'($urandom);
			@(posedge ref_clk);
			{ecc_valid, ecc_double, ecc_single, ecc_disabled} <= {1'b1, eb};
			@(posedge ref_clk);
			ecc_valid <= 1'b0;
			ca = {28'h0, eb[2], 1'h0, eb[1:0]};
			rd(FSF_OFF_ECC, ca, 32'hFFFF, 1'b0);
		end
		// Masked status does not raise the interrupt
		wr(FSF_OFF_IRQ_MASK, 32'h0, 1'b0);
		repeat (2) @(negedge ref_clk);
		check_bit("irq", 1'b0, irq);
		rd(FSF_OFF_IRQ_STAT, 32'h18, 32'h18, 1'b0);
		wr(FSF_OFF_IRQ_MASK, 32'h1F, 1'b0);
		repeat (2) @(negedge ref_clk);
		check_bit("irq", 1'b1, irq);
		wr(FSF_OFF_IRQ_STAT, 32'h1F, 1'b0);
		repeat (2) @(negedge ref_clk);
		check_bit("irq", 1'b0, irq);
		$display("test ecc done");
		conclude();
	end
endmodule : testbench
`default_nettype wire
